// File: rtl/fpe_regs.svh
// register offsets, field positions, reset values and timing counts of the flash controller
`ifndef FPE_REGS_SVH
`define FPE_REGS_SVH
`define FPE_ADDR_W 12
`define FPE_OFF_OP_STATE 12'h400
`define FPE_OFF_ACCESS_MODE 12'h504
`define FPE_OFF_PAGE_WIPE 12'h508
`define FPE_OFF_LEGACY_WIPE_A 12'h508
`define FPE_OFF_BULK_WIPE 12'h50c
`define FPE_OFF_LEGACY_WIPE_B 12'h510
`define FPE_OFF_USER_CFG_WIPE 12'h514
`define FPE_MODE_READ 2'h0
`define FPE_MODE_PROG 2'h1
`define FPE_MODE_ERASE 2'h2
`define FPE_MODE_RST 2'h0
`define FPE_READY_BIT 0
`define FPE_TRIG_BIT 0
`define FPE_SIZE_WORD 2'h2
`define FPE_RESP_OKAY 2'h0
`define FPE_RESP_DECERR 2'h3
`define FPE_CLK_PS 4000
`define FPE_T_WRITE_PS 40000000
`define FPE_T_PAGE_PS 85000000
`define FPE_T_ALL_PS 170000000
`define FPE_WRITE_CYC ((`FPE_T_WRITE_PS) / (`FPE_CLK_PS))
`define FPE_PAGE_CYC ((`FPE_T_PAGE_PS) / (`FPE_CLK_PS))
`define FPE_ALL_CYC ((`FPE_T_ALL_PS) / (`FPE_CLK_PS))
`endif

// File: rtl/fpe_pkg.sv
// types shared by the flash program and erase controller
package fpe_pkg;
  typedef enum logic [2:0] {OP_NONE, OP_PROG, OP_PAGE, OP_UCFG, OP_ALL} fpe_op_type;
  typedef enum logic {ST_IDLE, ST_BUSY} fpe_state_type;
  typedef struct packed {
    fpe_op_type op;
    logic [31:0] addr;
    logic [31:0] data;
  } fpe_cmd_type;
endpackage

// File: rtl/fpe_flash_ctrl.sv
// flash program and erase controller with an axi4-lite register port
// Overview of operation
// - access mode 0 read only, 1 program, 2 erase; resets to read only
// - in program mode each aligned word write made while idle programs that 32-bit word; writes while busy are dropped
// - programming only clears ones to zero; only erase restores ones
// - byte or halfword flash writes are rejected with a hard fault
// - instruction fetches from flash stall while an operation runs
// - status bit reads 0 while busy and 1 when idle
// - page address to page wipe register in erase mode erases that page
// - an erased page reads back all ones
// - erase triggers act only in erase mode
// - user config area is programmed like flash, takes effect after reset
// - writing 1 to user config wipe erases it in erase mode; 0 ignored
// - writing 1 to bulk wipe erases flash and user config; 0 ignored
// - both legacy page wipe registers act as the page wipe register
`timescale 1ns/1ps
`default_nettype none
`include "fpe_regs.svh"
module fpe_flash_ctrl
  import fpe_pkg::*;
#(
  parameter int WRITE_CYC = `FPE_WRITE_CYC,
  parameter int PAGE_CYC = `FPE_PAGE_CYC,
  parameter int ALL_CYC = `FPE_ALL_CYC
)(
  input wire logic clk_sys_in,
  input wire logic srst_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [11:0] s_axi_awaddr_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  output logic [1:0] s_axi_bresp_out,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  input wire logic [11:0] s_axi_araddr_in,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  input wire logic fw_valid_in,
  input wire logic [31:0] fw_addr_in,
  input wire logic [31:0] fw_data_in,
  input wire logic [1:0] fw_size_in,
  input wire logic [31:0] fl_cur_word_in,
  output logic fw_fault_out,
  output logic fetch_stall_out,
  output logic fl_start_out,
  output fpe_cmd_type fl_cmd_out
);

  // mapped offsets of the register window
  function automatic logic is_mapped(input logic [11:0] a);
    is_mapped = (a == `FPE_OFF_OP_STATE) || (a == `FPE_OFF_ACCESS_MODE) ||
                (a == `FPE_OFF_PAGE_WIPE) || (a == `FPE_OFF_BULK_WIPE) ||
                (a == `FPE_OFF_LEGACY_WIPE_B) || (a == `FPE_OFF_USER_CFG_WIPE);
  endfunction

  // length of each operation in clock cycles
  function automatic logic [31:0] op_cycles(input fpe_op_type op);
    case (op)
      OP_PROG: op_cycles = 32'(WRITE_CYC);
      OP_PAGE: op_cycles = 32'(PAGE_CYC);
      OP_UCFG: op_cycles = 32'(PAGE_CYC);
      OP_ALL: op_cycles = 32'(ALL_CYC);
      default: op_cycles = 32'h0000_0001;
    endcase
  endfunction

  logic aw_held_q, aw_held_d;
  logic w_held_q, w_held_d;
  logic [11:0] aw_addr_q, aw_addr_d;
  logic [31:0] w_data_q, w_data_d;
  logic awready_q, awready_d;
  logic wready_q, wready_d;
  logic bvalid_q, bvalid_d;
  logic [1:0] bresp_q, bresp_d;
  logic arready_q, arready_d;
  logic rvalid_q, rvalid_d;
  logic [31:0] rdata_q, rdata_d;
  logic [1:0] rresp_q, rresp_d;
  logic [1:0] mode_q, mode_d;
  logic [31:0] page_addr_q, page_addr_d;
  fpe_state_type state_q, state_d;
  logic [31:0] cnt_q, cnt_d;
  fpe_cmd_type cmd_q, cmd_d;
  logic start_q, start_d;
  logic fault_q, fault_d;
  logic wr_go;
  fpe_op_type req_op;
  logic [31:0] req_addr;
  logic [31:0] req_data;

  // a register write commits once address and data are both held
  assign wr_go = aw_held_q && w_held_q && !bvalid_q;

  // axi write channels: address and data taken in either order
  always_comb
  begin
    aw_held_d = aw_held_q;
    w_held_d = w_held_q;
    aw_addr_d = aw_addr_q;
    w_data_d = w_data_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    mode_d = mode_q;
    page_addr_d = page_addr_q;
    if (s_axi_awvalid_in && awready_q)
    begin
      aw_held_d = 1'b1;
      aw_addr_d = s_axi_awaddr_in;
    end
    if (s_axi_wvalid_in && wready_q)
    begin
      w_held_d = 1'b1;
      w_data_d = s_axi_wdata_in;
    end
    if (wr_go)
    begin
      aw_held_d = 1'b0;
      w_held_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = is_mapped(aw_addr_q) ? `FPE_RESP_OKAY : `FPE_RESP_DECERR;
      if (aw_addr_q == `FPE_OFF_ACCESS_MODE)
        mode_d = w_data_q[1:0];
      if (aw_addr_q == `FPE_OFF_PAGE_WIPE || aw_addr_q == `FPE_OFF_LEGACY_WIPE_B)
        page_addr_d = w_data_q;
    end
    else if (bvalid_q && s_axi_bready_in)
      bvalid_d = 1'b0;
    awready_d = !aw_held_d && !bvalid_d;
    wready_d = !w_held_d && !bvalid_d;
  end

  // axi read channel: one read at a time, answered one cycle after address
  always_comb
  begin
    rvalid_d = rvalid_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    if (s_axi_arvalid_in && arready_q)
    begin
      rvalid_d = 1'b1;
      rresp_d = is_mapped(s_axi_araddr_in) ? `FPE_RESP_OKAY : `FPE_RESP_DECERR;
      rdata_d = 32'h0000_0000;
      if (s_axi_araddr_in == `FPE_OFF_OP_STATE)
        rdata_d[`FPE_READY_BIT] = (state_q == ST_IDLE);
      else if (s_axi_araddr_in == `FPE_OFF_ACCESS_MODE)
        rdata_d[1:0] = mode_q;
      else if (s_axi_araddr_in == `FPE_OFF_PAGE_WIPE ||
               s_axi_araddr_in == `FPE_OFF_LEGACY_WIPE_B)
        rdata_d = page_addr_q;
    end
    else if (rvalid_q && s_axi_rready_in)
      rvalid_d = 1'b0;
    arready_d = !rvalid_d;
  end

  // request decode: register triggers and flash word writes
  always_comb
  begin
    req_op = OP_NONE;
    req_addr = 32'h0000_0000;
    req_data = 32'hffff_ffff;
    if (wr_go && mode_q == `FPE_MODE_ERASE)
    begin
      if (aw_addr_q == `FPE_OFF_PAGE_WIPE || aw_addr_q == `FPE_OFF_LEGACY_WIPE_B)
      begin
        req_op = OP_PAGE;
        req_addr = w_data_q;
      end
      else if (aw_addr_q == `FPE_OFF_BULK_WIPE && w_data_q[`FPE_TRIG_BIT])
        req_op = OP_ALL;
      else if (aw_addr_q == `FPE_OFF_USER_CFG_WIPE && w_data_q[`FPE_TRIG_BIT])
        req_op = OP_UCFG;
    end
    else if (fw_valid_in && mode_q == `FPE_MODE_PROG &&
             fw_size_in == `FPE_SIZE_WORD && fw_addr_in[1:0] == 2'h0)
    begin
      req_op = OP_PROG;
      req_addr = fw_addr_in;
      req_data = fw_data_in & fl_cur_word_in;
    end
  end

  // operation sequencer and fault reporting
  always_comb
  begin
    state_d = state_q;
    cnt_d = cnt_q;
    cmd_d = cmd_q;
    start_d = 1'b0;
    fault_d = fw_valid_in &&
              (fw_size_in != `FPE_SIZE_WORD || fw_addr_in[1:0] != 2'h0);
    case (state_q)
      ST_IDLE:
      begin
        if (req_op != OP_NONE)
        begin
          state_d = ST_BUSY;
          cnt_d = op_cycles(req_op) - 32'h0000_0001;
          cmd_d.op = req_op;
          cmd_d.addr = req_addr;
          cmd_d.data = req_data;
          start_d = 1'b1;
        end
      end
      ST_BUSY:
      begin
        if (cnt_q == 32'h0000_0000)
          state_d = ST_IDLE;
        else
          cnt_d = cnt_q - 32'h0000_0001;
      end
      default: state_d = ST_IDLE;
    endcase
  end

  // state registers
  always_ff @(posedge clk_sys_in)
  begin
    if (srst_in)
    begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      aw_addr_q <= 12'h000;
      w_data_q <= 32'h0000_0000;
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= 2'h0;
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= 2'h0;
      mode_q <= `FPE_MODE_RST;
      page_addr_q <= 32'h0000_0000;
      state_q <= ST_IDLE;
      cnt_q <= 32'h0000_0000;
      cmd_q <= '0;
      start_q <= 1'b0;
      fault_q <= 1'b0;
    end
    else
    begin
      aw_held_q <= aw_held_d;
      w_held_q <= w_held_d;
      aw_addr_q <= aw_addr_d;
      w_data_q <= w_data_d;
      awready_q <= awready_d;
      wready_q <= wready_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      arready_q <= arready_d;
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
      mode_q <= mode_d;
      page_addr_q <= page_addr_d;
      state_q <= state_d;
      cnt_q <= cnt_d;
      cmd_q <= cmd_d;
      start_q <= start_d;
      fault_q <= fault_d;
    end
  end

  // outputs straight from flip-flops
  assign s_axi_awready_out = awready_q;
  assign s_axi_wready_out = wready_q;
  assign s_axi_bvalid_out = bvalid_q;
  assign s_axi_bresp_out = bresp_q;
  assign s_axi_arready_out = arready_q;
  assign s_axi_rvalid_out = rvalid_q;
  assign s_axi_rdata_out = rdata_q;
  assign s_axi_rresp_out = rresp_q;
  assign fw_fault_out = fault_q;
  assign fetch_stall_out = (state_q == ST_BUSY);
  assign fl_start_out = start_q;
  assign fl_cmd_out = cmd_q;

  // checks
  property p_mode_reset;
    @(posedge clk_sys_in) srst_in |=> mode_q == `FPE_MODE_READ;
  endproperty
  a_mode_reset: assert property (p_mode_reset) else $error("mode not read only after reset");

  property p_prog_start;
    @(posedge clk_sys_in) disable iff (srst_in)
      (fw_valid_in && mode_q == `FPE_MODE_PROG && fw_size_in == `FPE_SIZE_WORD &&
       fw_addr_in[1:0] == 2'h0 && !fetch_stall_out && !wr_go)
      |=> fl_start_out && fl_cmd_out.op == OP_PROG && fl_cmd_out.addr == $past(fw_addr_in);
  endproperty
  a_prog_start: assert property (p_prog_start) else $error("word write did not program");

  property p_prog_clears;
    @(posedge clk_sys_in) disable iff (srst_in)
      fl_start_out && fl_cmd_out.op == OP_PROG |-> (fl_cmd_out.data & ~$past(fl_cur_word_in)) == 32'h0;
  endproperty
  a_prog_clears: assert property (p_prog_clears) else $error("program sets a zero bit");

  property p_fault;
    @(posedge clk_sys_in) disable iff (srst_in)
      fw_valid_in && fw_size_in != `FPE_SIZE_WORD
      |=> fw_fault_out && !(fl_start_out && fl_cmd_out.op == OP_PROG);
  endproperty
  a_fault: assert property (p_fault) else $error("narrow write not faulted");

  property p_stall;
    @(posedge clk_sys_in) disable iff (srst_in)
      fl_start_out |-> fetch_stall_out ##1 fetch_stall_out;
  endproperty
  a_stall: assert property (p_stall) else $error("fetch not stalled during operation");

  property p_ready_read;
    @(posedge clk_sys_in) disable iff (srst_in)
      s_axi_arvalid_in && s_axi_arready_out && s_axi_araddr_in == `FPE_OFF_OP_STATE
      |=> s_axi_rvalid_out && s_axi_rdata_out[0] == !$past(fetch_stall_out);
  endproperty
  a_ready_read: assert property (p_ready_read) else $error("status bit wrong");

  property p_erase_mode;
    @(posedge clk_sys_in) disable iff (srst_in)
      fl_start_out && fl_cmd_out.op != OP_PROG |-> $past(mode_q) == `FPE_MODE_ERASE;
  endproperty
  a_erase_mode: assert property (p_erase_mode) else $error("erase outside erase mode");

  property p_page_len;
    @(posedge clk_sys_in) disable iff (srst_in)
      fl_start_out && fl_cmd_out.op == OP_PAGE |-> cnt_q == 32'(PAGE_CYC) - 32'h1 ##1 fetch_stall_out[*4];
  endproperty
  a_page_len: assert property (p_page_len) else $error("page erase shortened");

  property p_busy_ignore;
    @(posedge clk_sys_in) disable iff (srst_in)
      fetch_stall_out && cnt_q != 32'h0 |=> !fl_start_out;
  endproperty
  a_busy_ignore: assert property (p_busy_ignore) else $error("request taken while busy");

endmodule
`default_nettype wire

// File: test/fpe_flash_model.sv
// behavioural flash array and user config area facing the controller
`timescale 1ns/1ps
`default_nettype none
module fpe_flash_model
  import fpe_pkg::*;
(
  input wire logic clk_in,
  input wire logic start_in,
  input wire fpe_cmd_type cmd_in,
  input wire logic [31:0] addr_in,
  output logic [31:0] word_out
);
  logic [31:0] mem [0:15];
  logic [31:0] ucfg [0:3];
  // mixed start pattern so that both erase and program effects show
  initial
  begin
    for (int i = 0; i < 16; i++)
      mem[i] = 32'h5a5a_f00f ^ i;
    for (int i = 0; i < 4; i++)
      ucfg[i] = 32'h0ff0_3cc3 ^ i;
  end
  // address bit 28 selects the config area; a page is four words
  assign word_out = addr_in[28] ? ucfg[addr_in[3:2]] : mem[addr_in[5:2]];
  // apply each operation as it starts
  always @(posedge clk_in)
  begin
    if (start_in)
    begin
      for (int i = 0; i < 16; i++)
        if (cmd_in.op == OP_ALL || (cmd_in.op == OP_PAGE && i[3:2] == cmd_in.addr[5:4]))
          mem[i] = '1;
      for (int i = 0; i < 4; i++)
        if (cmd_in.op == OP_ALL || cmd_in.op == OP_UCFG)
          ucfg[i] = '1;
      if (cmd_in.op == OP_PROG && cmd_in.addr[28])
        ucfg[cmd_in.addr[3:2]] = ucfg[cmd_in.addr[3:2]] & cmd_in.data;
      else if (cmd_in.op == OP_PROG)
        mem[cmd_in.addr[5:2]] = mem[cmd_in.addr[5:2]] & cmd_in.data;
    end
  end
endmodule
`default_nettype wire

// File: test/flash_program_erase_ctrl_bench.sv
// self-checking bench for the flash program and erase controller
`timescale 1ns/1ps
`default_nettype none
module flash_program_erase_ctrl_bench
  import fpe_pkg::*;
();
  logic clk = 1'b0, srst = 1'b1, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, fw_valid = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, fault, stall, start;
  logic [11:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, fw_addr = '0, fw_data = '0, rdata, cur;
  logic [1:0] fw_size = 2'h2, bresp, rresp;
  logic [31:0] exp_m [0:15];
  logic [31:0] exp_u [0:3];
  fpe_cmd_type cmd;
  fpe_cmd_type got_cmd [$];
  int got_len [$];
  int run = 0, faults = 0, errors = 0, checked = 0;
  fpe_flash_ctrl #(.WRITE_CYC(4), .PAGE_CYC(8), .ALL_CYC(12)) DUT (
    .clk_sys_in(clk), .srst_in(srst), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
    .s_axi_awaddr_in(awaddr), .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready),
    .s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hf), .s_axi_bvalid_out(bvalid),
    .s_axi_bready_in(bready), .s_axi_bresp_out(bresp), .s_axi_arvalid_in(arvalid),
    .s_axi_arready_out(arready), .s_axi_araddr_in(araddr), .s_axi_rvalid_out(rvalid),
    .s_axi_rready_in(rready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
    .fw_valid_in(fw_valid), .fw_addr_in(fw_addr), .fw_data_in(fw_data), .fw_size_in(fw_size),
    .fl_cur_word_in(cur), .fw_fault_out(fault), .fetch_stall_out(stall),
    .fl_start_out(start), .fl_cmd_out(cmd));
  fpe_flash_model FLM (.clk_in(clk), .start_in(start), .cmd_in(cmd), .addr_in(fw_addr),
    .word_out(cur));
  initial
  begin
    forever #2 clk = ~clk;
  end
  // record started operations, stall lengths and fault pulses
  always @(posedge clk)
  begin
    if (start === 1'b1)
      got_cmd.push_back(cmd);
    if (fault === 1'b1)
      faults++;
    if (stall === 1'b1)
      run++;
    else if (run != 0)
    begin
      got_len.push_back(run);
      run = 0;
    end
  end
  task automatic check_v(input logic [31:0] got, input logic [31:0] exp, input string what);
    checked++;
    if (got !== exp)
    begin
      errors++;
      $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic check_op(input fpe_op_type op, input logic [31:0] a, input logic [31:0] d,
    input int len);
    fpe_cmd_type c;
    int n;
    c = got_cmd.size() ? got_cmd.pop_front() : '0;
    n = got_len.size() ? got_len.pop_front() : 0;
    check_v(32'(c.op), 32'(op), "operation kind");
    if (op == OP_PROG || op == OP_PAGE)
      check_v(c.addr, a, "operation address");
    if (op == OP_PROG)
      check_v(c.data, d, "programmed word");
    check_v(n, len, "stall cycles");
  endtask
  task automatic check_mem();
    for (int i = 0; i < 16; i++)
      check_v(FLM.mem[i], exp_m[i], "flash word");
    for (int i = 0; i < 4; i++)
      check_v(FLM.ucfg[i], exp_u[i], "config word");
    check_v(got_cmd.size(), 0, "unexpected operation");
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    bit done = 0;
    @(posedge clk);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= d;
    bready <= 1'b1;
    for (int n = 0; n < 100 && !done; n++)
    begin
      @(posedge clk);
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
      if (bvalid && bready)
      begin
        check_v(bresp, 2'h0, "write response");
        bready <= 1'b0;
        done = 1;
      end
    end
    if (!done)
    begin
      errors++;
      $display("[FAIL] %0t write not answered", $time);
    end
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    bit done = 0;
    @(posedge clk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    for (int n = 0; n < 100 && !done; n++)
    begin
      @(posedge clk);
      if (arready)
        arvalid <= 1'b0;
      if (rvalid && rready)
      begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        done = 1;
      end
    end
    if (!done)
    begin
      errors++;
      $display("[FAIL] %0t read not answered", $time);
    end
  endtask
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    check_v(r, er, "read response");
    if (er == 2'h0)
      check_v(d, e, "read data");
  endtask
  task automatic fw_wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] s);
    @(posedge clk);
    fw_valid <= 1'b1;
    fw_addr <= a;
    fw_data <= d;
    fw_size <= s;
    @(posedge clk);
    fw_valid <= 1'b0;
  endtask
  task automatic wait_idle();
    logic [31:0] d = '0;
    logic [1:0] r;
    for (int n = 0; n < 50 && d[0] !== 1'b1; n++)
      rd(12'h400, d, r);
    if (d[0] !== 1'b1)
    begin
      errors++;
      $display("[FAIL] %0t controller never became ready", $time);
    end
    repeat (2) @(posedge clk);
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial
  begin
    #80000;
    errors++;
    $display("[FAIL] %0t watchdog expired", $time);
    print_verdict();
  end
  initial
  begin
    logic [31:0] d, e, a;
    int k, p, f;
    void'($urandom(32'ha770));
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    for (int i = 0; i < 16; i++)
      exp_m[i] = FLM.mem[i];
    for (int i = 0; i < 4; i++)
      exp_u[i] = FLM.ucfg[i];
    rd_chk(12'h400, 32'h1, 2'h0);
    rd_chk(12'h504, 32'h0, 2'h0);
    rd_chk(12'h508, 32'h0, 2'h0);
    rd_chk(12'h600, 32'h0, 2'h3);
    for (int m = 2; m >= 0; m--)
    begin
      wr(12'h504, m);
      rd_chk(12'h504, m, 2'h0);
    end
    $display("test reset and mode done");
    // program three words, the last in the config area, each followed by a dropped write
    wr(12'h504, 32'h1);
    for (int j = 0; j < 3; j++)
    begin
      k = (j == 2) ? $urandom_range(3) : (j * 8 + $urandom_range(7));
      a = (j == 2) ? (32'h1000_0000 | 32'(k * 4)) : 32'(k * 4);
      d = (j == 1) ? ($urandom() | 32'hffff_00ff) : $urandom();
      e = ((j == 2) ? exp_u[k] : exp_m[k]) & d;
      fw_wr(a, d, 2'h2);
      fw_wr(a ^ 32'h4, 32'h0, 2'h2);
      wait_idle();
      check_op(OP_PROG, a, e, 4);
      if (j == 2)
        exp_u[k] = e;
      else
        exp_m[k] = e;
    end
    // narrow or unaligned writes fault; triggers outside erase mode are ignored
    f = faults;
    fw_wr(32'h8, 32'h0, 2'h0);
    fw_wr(32'h8, 32'h0, 2'h1);
    fw_wr(32'ha, 32'h0, 2'h2);
    wr(12'h508, 32'h10);
    wr(12'h50c, 32'h1);
    wr(12'h514, 32'h1);
    repeat (4) @(posedge clk);
    check_v(faults, f + 3, "fault pulses");
    check_mem();
    $display("test program done");
    wr(12'h504, 32'h2);
    fw_wr(32'h0, 32'h0, 2'h2);
    foreach (exp_u[r])
    begin
      if (r > 1)
        continue;
      p = $urandom_range(3);
      wr(r ? 12'h510 : 12'h508, 32'(p * 16));
      rd_chk(12'h400, 32'h0, 2'h0);
      wait_idle();
      check_op(OP_PAGE, 32'(p * 16), 32'h0, 8);
      rd_chk(12'h508, 32'(p * 16), 2'h0);
      for (int i = 0; i < 16; i++)
        if (i[3:2] == p[1:0])
          exp_m[i] = '1;
      check_mem();
    end
    // zero writes to both triggers do nothing, ones start their erase
    for (int t = 0; t < 2; t++)
    begin
      wr(t ? 12'h50c : 12'h514, 32'h0);
      repeat (4) @(posedge clk);
      check_mem();
      wr(t ? 12'h50c : 12'h514, 32'h1);
      wait_idle();
      check_op(t ? OP_ALL : OP_UCFG, 32'h0, 32'h0, t ? 12 : 8);
      for (int i = 0; i < 16; i++)
        exp_m[i] = t ? '1 : exp_m[i];
      for (int i = 0; i < 4; i++)
        exp_u[i] = '1;
      check_mem();
    end
    wr(12'h504, 32'h0);
    $display("test erase done");
    print_verdict();
  end
endmodule
`default_nettype wire
